// >>> verilog/dsof_pkg.sv
// Package of constants and types for the drive status output flag block.
package dsof_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] DSOF_OFF_OVL_THR = 8'h00;
    localparam logic [7:0] DSOF_OFF_OVL2_THR = 8'h04;
    localparam logic [7:0] DSOF_OFF_DEV_THR = 8'h08;
    localparam logic [7:0] DSOF_OFF_FSEL = 8'h0c;
    localparam logic [7:0] DSOF_OFF_CTRL = 8'h10;
    localparam logic [7:0] DSOF_OFF_STATUS = 8'h14;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int DSOF_FSEL_OUT11_LSB = 0;
    localparam int DSOF_FSEL_OUT12_LSB = 8;
    localparam int DSOF_FSEL_ALM_LSB = 16;
    localparam int DSOF_CTRL_POL_BIT = 0;
    localparam int DSOF_CTRL_CLR_BIT = 1;

    // ----------------------------------------
    // Reset values; thresholds are in 0.1 % of rated quantity
    // ----------------------------------------
    localparam logic [15:0] DSOF_OVL_THR_RST = 16'h03e8;
    localparam logic [15:0] DSOF_OVL2_THR_RST = 16'h03e8;
    localparam logic [15:0] DSOF_DEV_THR_RST = 16'h001e;
    localparam logic [7:0] DSOF_OUT11_RST = 8'h03;
    localparam logic [7:0] DSOF_OUT12_RST = 8'h04;
    localparam logic [7:0] DSOF_ALM_RST = 8'h05;

    // ----------------------------------------
    // Output function selection codes
    // ----------------------------------------
    localparam logic [7:0] DSOF_FN_OVL = 8'h03;
    localparam logic [7:0] DSOF_FN_DEV = 8'h04;
    localparam logic [7:0] DSOF_FN_ALM = 8'h05;
    localparam logic [7:0] DSOF_FN_OVL2 = 8'h1a;

    // ----------------------------------------
    // AXI4-Lite response codes
    // ----------------------------------------
    localparam logic [1:0] DSOF_RESP_OKAY = 2'h0;
    localparam logic [1:0] DSOF_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DSOF_W_IDLE = 2'b01,
        DSOF_W_RESP = 2'b10
    } dsof_wstate_t;

endpackage : dsof_pkg

// >>> verilog/dsof_top.sv
// Drive status output flags: overload, loop deviation and fault alarm with relay routing.
//
// Overview of operation
// - First overload flag on when current above threshold, off when below.
// - Second overload flag works alike against its own threshold.
// - Overload detection runs while driving and while regenerating.
// - Relay contact closes while its overload flag is on, normally open.
// - First overload threshold resets to 100 percent, software may rewrite.
// - Function code 03 routes the first overload flag to a terminal.
// - Loop error is absolute difference of setpoint and process variable.
// - Deviation flag on above threshold, off below; function code 04.
// - Deviation threshold resets to 3 percent, software may rewrite.
// - Fault alarm flag holds during trip and releases when fault cleared.
// - Code 05 drives output on from alarm until cleared.
// - Fault alarm may go to either relay; alarm relay carries it by default.
// - Polarity setting inverts alarm relay contact sense.
`timescale 1ns/1ps
`default_nettype none

module dsof_top (
    input wire logic mclk,
    input wire logic nrst,
    // Measured quantities in 0.1 % units, sampled from the control clock domain.
    input wire logic [15:0] out_current,
    input wire logic [15:0] pid_setpoint,
    input wire logic [15:0] pid_feedback,
    input wire logic trip_mode,
    input wire logic fault_clear,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Relay drives.
    output logic relay11_close,
    output logic relay12_close,
    output logic alarm_relay_contact_a,
    output logic alarm_relay_contact_b
);
    import dsof_pkg::*;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // Hysteresis-free compare that holds the old value at exact equality.
    function automatic logic dsof_cmp(input logic [15:0] val, input logic [15:0] thr,
                                      input logic prev);
        dsof_cmp = (val > thr) ? 1'b1 : ((val < thr) ? 1'b0 : prev);
    endfunction : dsof_cmp

    // Byte-lane merge of a write into a register word.
    function automatic logic [31:0] dsof_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            dsof_merge[i*8 +: 8] = st[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : dsof_merge

    // Selects a flag according to a terminal function code.
    function automatic logic dsof_route(input logic [7:0] code, input logic [3:0] flags);
        dsof_route = (code == DSOF_FN_OVL) ? flags[0] :
                     (code == DSOF_FN_OVL2) ? flags[1] :
                     (code == DSOF_FN_DEV) ? flags[2] :
                     (code == DSOF_FN_ALM) ? flags[3] : 1'b0;
    endfunction : dsof_route

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [15:0] overload_threshold_r;
    logic [15:0] second_overload_threshold_r;
    logic [15:0] deviation_threshold_r;
    logic [23:0] fsel_r;
    logic alarm_relay_polarity_r;
    logic sw_clear_r;
    logic overload_notice_flag_r;
    logic second_overload_notice_flag_r;
    logic loop_deviation_flag_r;
    logic fault_alarm_flag_r;
    logic [2:0] trip_sync_r;
    logic [2:0] clr_sync_r;
    logic trip_q_r;
    logic clr_q_r;
    dsof_wstate_t wstate_r;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------

    // Three-stage synchronisers; a level counts once stages two and three agree.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            trip_sync_r <= 3'h0;
            clr_sync_r <= 3'h0;
            trip_q_r <= 1'b0;
            clr_q_r <= 1'b0;
        end else begin
            trip_sync_r <= {trip_sync_r[1:0], trip_mode};
            clr_sync_r <= {clr_sync_r[1:0], fault_clear};
            if (trip_sync_r[1] == trip_sync_r[2]) begin
                trip_q_r <= trip_sync_r[2];
            end
            if (clr_sync_r[1] == clr_sync_r[2]) begin
                clr_q_r <= clr_sync_r[2];
            end
        end
    end

    // ----------------------------------------
    // Flag evaluation
    // ----------------------------------------
    wire logic [15:0] err_mag;
    wire logic ovl_nxt;
    wire logic ovl2_nxt;
    wire logic dev_nxt;
    wire logic alarm_nxt;
    wire logic any_clear;

    assign err_mag = (pid_setpoint >= pid_feedback) ? (pid_setpoint - pid_feedback)
                                                    : (pid_feedback - pid_setpoint);
    // first overload compare, independent of motoring direction.
    assign ovl_nxt = dsof_cmp(out_current, overload_threshold_r, overload_notice_flag_r);
    assign ovl2_nxt = dsof_cmp(out_current, second_overload_threshold_r,
                               second_overload_notice_flag_r);
    assign dev_nxt = dsof_cmp(err_mag, deviation_threshold_r, loop_deviation_flag_r);
    assign any_clear = clr_q_r | sw_clear_r;
    // alarm latches on trip; a new trip wins over a clear.
    assign alarm_nxt = trip_q_r ? 1'b1 : (any_clear ? 1'b0 : fault_alarm_flag_r);

    // Flag registers.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            overload_notice_flag_r <= 1'b0;
            second_overload_notice_flag_r <= 1'b0;
            loop_deviation_flag_r <= 1'b0;
            fault_alarm_flag_r <= 1'b0;
        end else begin
            overload_notice_flag_r <= ovl_nxt;
            second_overload_notice_flag_r <= ovl2_nxt;
            loop_deviation_flag_r <= dev_nxt;
            fault_alarm_flag_r <= alarm_nxt;
        end
    end

    // ----------------------------------------
    // Output routing
    // ----------------------------------------
    wire logic [3:0] flag_vec;
    wire logic out11_nxt;
    wire logic out12_nxt;
    wire logic alm_nxt;

    // Flag vector feeds both the relay routing and the status register.
    assign flag_vec = {fault_alarm_flag_r, loop_deviation_flag_r,
                       second_overload_notice_flag_r, overload_notice_flag_r};
    // function codes pick the flag for each relay.
    assign out11_nxt = dsof_route(fsel_r[DSOF_FSEL_OUT11_LSB +: 8], flag_vec);
    assign out12_nxt = dsof_route(fsel_r[DSOF_FSEL_OUT12_LSB +: 8], flag_vec);
    assign alm_nxt = dsof_route(fsel_r[DSOF_FSEL_ALM_LSB +: 8], flag_vec);

    // relay drives, normally open, alarm relay invertible.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            relay11_close <= 1'b0;
            relay12_close <= 1'b0;
            alarm_relay_contact_a <= 1'b0;
            alarm_relay_contact_b <= 1'b1;
        end else begin
            relay11_close <= out11_nxt;
            relay12_close <= out12_nxt;
            alarm_relay_contact_a <= alm_nxt ^ alarm_relay_polarity_r;
            alarm_relay_contact_b <= ~(alm_nxt ^ alarm_relay_polarity_r);
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    wire logic aw_take;
    wire logic w_take;
    wire logic wr_go;
    wire logic [7:0] wr_addr;
    wire logic [31:0] wr_data;
    wire logic [3:0] wr_strb;
    wire logic wr_hit;

    // Handshake decode; a half held from an earlier edge wins over the live bus.
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_got_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
    assign wr_go = (wstate_r == DSOF_W_IDLE) & (aw_got_r | aw_take) & (w_got_r | w_take);
    assign wr_hit = (wr_addr == DSOF_OFF_OVL_THR) | (wr_addr == DSOF_OFF_OVL2_THR) |
                    (wr_addr == DSOF_OFF_DEV_THR) | (wr_addr == DSOF_OFF_FSEL) |
                    (wr_addr == DSOF_OFF_CTRL);

    // Address and data may arrive in either order; the response follows both.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wstate_r <= DSOF_W_IDLE;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= DSOF_RESP_OKAY;
        end else begin
            unique case (wstate_r)
                DSOF_W_IDLE: begin
                    if (aw_take) begin
                        aw_got_r <= 1'b1;
                        awaddr_r <= s_axi_awaddr;
                    end
                    if (w_take) begin
                        w_got_r <= 1'b1;
                        wdata_r <= s_axi_wdata;
                        wstrb_r <= s_axi_wstrb;
                    end
                    s_axi_awready <= ~(aw_got_r | aw_take) & ~wr_go;
                    s_axi_wready <= ~(w_got_r | w_take) & ~wr_go;
                    if (wr_go) begin
                        wstate_r <= DSOF_W_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? DSOF_RESP_OKAY : DSOF_RESP_SLVERR;
                    end
                end
                DSOF_W_RESP: begin
                    aw_got_r <= 1'b0;
                    w_got_r <= 1'b0;
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                        wstate_r <= DSOF_W_IDLE;
                    end
                end
            endcase
        end
    end

    // thresholds reset to defaults and take software writes.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            overload_threshold_r <= DSOF_OVL_THR_RST;
            second_overload_threshold_r <= DSOF_OVL2_THR_RST;
            deviation_threshold_r <= DSOF_DEV_THR_RST;
            fsel_r <= {DSOF_ALM_RST, DSOF_OUT12_RST, DSOF_OUT11_RST};
            alarm_relay_polarity_r <= 1'b0;
            sw_clear_r <= 1'b0;
        end else begin
            sw_clear_r <= 1'b0;
            if (wr_go && wr_addr == DSOF_OFF_OVL_THR) begin
                overload_threshold_r <= 16'(dsof_merge({16'h0, overload_threshold_r},
                                                       wr_data, wr_strb));
            end
            if (wr_go && wr_addr == DSOF_OFF_OVL2_THR) begin
                second_overload_threshold_r <= 16'(dsof_merge(
                    {16'h0, second_overload_threshold_r}, wr_data, wr_strb));
            end
            if (wr_go && wr_addr == DSOF_OFF_DEV_THR) begin
                deviation_threshold_r <= 16'(dsof_merge({16'h0, deviation_threshold_r},
                                                        wr_data, wr_strb));
            end
            if (wr_go && wr_addr == DSOF_OFF_FSEL) begin
                fsel_r <= 24'(dsof_merge({8'h0, fsel_r}, wr_data, wr_strb));
            end
            if (wr_go && wr_addr == DSOF_OFF_CTRL && wr_strb[0]) begin
                alarm_relay_polarity_r <= wr_data[DSOF_CTRL_POL_BIT];
                sw_clear_r <= wr_data[DSOF_CTRL_CLR_BIT];
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    wire logic [31:0] rd_word;
    wire logic rd_hit;

    assign rd_hit = (s_axi_araddr == DSOF_OFF_OVL_THR) | (s_axi_araddr == DSOF_OFF_OVL2_THR) |
                    (s_axi_araddr == DSOF_OFF_DEV_THR) | (s_axi_araddr == DSOF_OFF_FSEL) |
                    (s_axi_araddr == DSOF_OFF_CTRL) | (s_axi_araddr == DSOF_OFF_STATUS);
    assign rd_word =
        (s_axi_araddr == DSOF_OFF_OVL_THR) ? {16'h0, overload_threshold_r} :
        (s_axi_araddr == DSOF_OFF_OVL2_THR) ? {16'h0, second_overload_threshold_r} :
        (s_axi_araddr == DSOF_OFF_DEV_THR) ? {16'h0, deviation_threshold_r} :
        (s_axi_araddr == DSOF_OFF_FSEL) ? {8'h0, fsel_r} :
        (s_axi_araddr == DSOF_OFF_CTRL) ? {31'h0, alarm_relay_polarity_r} :
        (s_axi_araddr == DSOF_OFF_STATUS) ? {28'h0, flag_vec} : 32'h0000_0000;

    // One read at a time; arready drops while the answer stands.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= DSOF_RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? DSOF_RESP_OKAY : DSOF_RESP_SLVERR;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

endmodule : dsof_top

`default_nettype wire

// >>> verification/dsof_checker_sva.sv
// Concurrent assertions for the drive status output flag block.
`timescale 1ns/1ps
`default_nettype none
module dsof_checker (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [15:0] out_current,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic relay11_close,
    input wire logic relay12_close,
    input wire logic alarm_relay_contact_a,
    input wire logic alarm_relay_contact_b
);
    import dsof_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    logic [15:0] thr_r;
    logic [7:0] sel11_r;
    logic wr_fire;
    // Shadow of the first threshold and relay 11 selection, fed by full-word writes.
    assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            thr_r <= DSOF_OVL_THR_RST;
            sel11_r <= DSOF_OUT11_RST;
        end else if (wr_fire && s_axi_awaddr == DSOF_OFF_OVL_THR) begin
            thr_r <= s_axi_wdata[15:0];
        end else if (wr_fire && s_axi_awaddr == DSOF_OFF_FSEL) begin
            sel11_r <= s_axi_wdata[DSOF_FSEL_OUT11_LSB +: 8];
        end
    end
    // Steps of an overload episode seen on relay 11.
    sequence s_over;
        (sel11_r == DSOF_FN_OVL) && (out_current > thr_r);
    endsequence
    sequence s_under;
        (sel11_r == DSOF_FN_OVL) && (out_current < thr_r);
    endsequence
    property p_rst;
        !nrst |=> !relay11_close && !relay12_close && !alarm_relay_contact_a && !s_axi_bvalid;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_ovl_on;
        disable iff (!nrst) s_over [*3] |=> relay11_close;
    endproperty
    a_ovl_on: assert property (p_ovl_on) else $error("relay 11 open in overload");
    property p_ovl_off;
        disable iff (!nrst) s_under [*3] |=> !relay11_close;
    endproperty
    a_ovl_off: assert property (p_ovl_off) else $error("relay 11 closed below limit");
    property p_contact;
        disable iff (!nrst) alarm_relay_contact_b == !alarm_relay_contact_a;
    endproperty
    a_contact: assert property (p_contact) else $error("alarm contacts not exclusive");
    property p_bresp;
        disable iff (!nrst) wr_fire |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("no write response");
    property p_bhold;
        disable iff (!nrst) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rresp;
        disable iff (!nrst) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rresp: assert property (p_rresp) else $error("no read response");
    property p_rhold;
        disable iff (!nrst) s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data changed");
    property p_wblock;
        disable iff (!nrst) s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wblock: assert property (p_wblock) else $error("write taken while busy");
    property p_rblock;
        disable iff (!nrst) s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rblock: assert property (p_rblock) else $error("read taken while busy");
endmodule : dsof_checker
bind dsof_top dsof_checker u_chk (.mclk, .nrst, .out_current, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .relay11_close, .relay12_close, .alarm_relay_contact_a,
    .alarm_relay_contact_b);
`default_nettype wire

// >>> verification/dsof_relay_model.sv
// Behavioural model of the relay coils and contacts outside the block.
`timescale 1ns/1ps
`default_nettype none
module dsof_relay_model (
    input wire logic mclk,
    input wire logic relay11_close,
    input wire logic relay12_close,
    input wire logic alarm_relay_contact_a,
    input wire logic alarm_relay_contact_b,
    output logic coil11,
    output logic coil12,
    output logic coil_a,
    output logic coil_b
);
    // Contacts follow their drives one clock late, like a slow armature.
    always_ff @(posedge mclk) begin
        coil11 <= relay11_close;
        coil12 <= relay12_close;
        coil_a <= alarm_relay_contact_a;
        coil_b <= alarm_relay_contact_b;
    end
endmodule : dsof_relay_model
`default_nettype wire

// >>> verification/drive_status_output_flags_test.sv
// Self-checking testbench for the drive status output flag block.
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_flags_test;
    import dsof_pkg::*;
    logic mclk, nrst, trip_mode, fault_clear, awvalid, wvalid, bready, arvalid, rready;
    logic [15:0] out_current, pid_setpoint, pid_feedback;
    logic [7:0] awaddr, araddr, sel11;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    wire logic awready, wready, bvalid, arready, rvalid, r11, r12, ca, cb;
    wire logic coil11, coil12, coil_a, coil_b;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int failures, checks_done, seed, otr, o2tr, dtr, cv, dv;
    logic oe, o2e, de;
    logic [33:0] bq[$], rq[$];
    dsof_top u_dut (.mclk, .nrst, .out_current, .pid_setpoint, .pid_feedback, .trip_mode,
        .fault_clear, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .relay11_close(r11), .relay12_close(r12), .alarm_relay_contact_a(ca),
        .alarm_relay_contact_b(cb));
    dsof_relay_model u_relays (.mclk, .relay11_close(r11), .relay12_close(r12),
        .alarm_relay_contact_a(ca), .alarm_relay_contact_b(cb), .coil11, .coil12, .coil_a,
        .coil_b);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic cmp(input string nm, input logic [33:0] e, input logic [33:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic results;
        if (failures == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    // --------------------------------
    // Bus master tasks
    // --------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bit ad, wd;
        bq.push_back({32'h0, e});
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge mclk);
            if (!ad && awready) ad = 1'b1;
            if (!wd && wready) wd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        do @(posedge mclk); while (!bvalid);
        bready <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
        rready <= 1'b0;
        @(posedge mclk);
    endtask : rd
    // Response monitor pairs each answer with the oldest expectation.
    always @(posedge mclk) begin
        if (rvalid && rready) cmp("read", rq.pop_front(), {rresp, rdata});
        if (bvalid && bready) cmp("bresp", bq.pop_front(), {32'h0, bresp});
    end
    // Flag model: equality keeps the previous state.
    task automatic eval;
        int m;
        m = (dv < 0) ? -dv : dv;
        if (cv > otr) oe = 1'b1;
        else if (cv < otr) oe = 1'b0;
        if (cv > o2tr) o2e = 1'b1;
        else if (cv < o2tr) o2e = 1'b0;
        if (m > dtr) de = 1'b1;
        else if (m < dtr) de = 1'b0;
    endtask : eval
    task automatic step(input int i);
        int s;
        s = 16'h2000 + ($random(seed) & 16'h0fff);
        cv = (i % 7 == 0) ? otr : otr + $random(seed) % 40;
        dv = (i % 5 == 0) ? dtr : dtr + $random(seed) % 20;
        if (i % 2 == 1) dv = -dv;
        out_current <= 16'(cv);
        pid_setpoint <= 16'(s);
        pid_feedback <= 16'(s - dv);
        eval();
        repeat (4) @(posedge mclk);
        cmp("relay11", {33'h0, (sel11 == 8'h03) ? oe : o2e}, {33'h0, coil11});
        cmp("relay12", {33'h0, de}, {33'h0, coil12});
        rd(8'h14, {2'h0, 28'h0, 1'b0, de, o2e, oe});
    endtask : step
    initial begin
        #300000;
        failures++;
        results();
    end
    initial begin
        {trip_mode, fault_clear, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
        {out_current, pid_setpoint, pid_feedback, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        seed = 47;
        {oe, o2e, de} = 3'h0;
        {otr, o2tr, dtr, cv, dv, sel11} = {32'd1000, 32'd1000, 32'd30, 32'd0, 32'd0, 8'h03};
        nrst = 1'b0;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd(8'h00, {2'h0, 32'h3e8});
        rd(8'h04, {2'h0, 32'h3e8});
        rd(8'h08, {2'h0, 32'h1e});
        rd(8'h0c, {2'h0, 32'h050403});
        rd(8'h18, {DSOF_RESP_SLVERR, 32'h0});
        for (int i = 0; i < 14; i++) step(i);
        otr = 16'h0100 + ($random(seed) & 16'h03ff);
        o2tr = otr + $random(seed) % 30;
        dtr = 16'h0040 + ($random(seed) & 16'h00ff);
        sel11 = 8'h1a;
        wr(8'h00, 32'(otr), DSOF_RESP_OKAY);
        wr(8'h04, 32'(o2tr), DSOF_RESP_OKAY);
        wr(8'h08, 32'(dtr), DSOF_RESP_OKAY);
        wr(8'h0c, 32'h0005041a, DSOF_RESP_OKAY);
        eval();
        for (int i = 1; i < 15; i++) step(i);
        trip_mode <= 1'b1;
        repeat (12) @(posedge mclk);
        cmp("contact_a", 34'h1, {33'h0, coil_a});
        rd(8'h14, {2'h0, 28'h0, 1'b1, de, o2e, oe});
        trip_mode <= 1'b0;
        repeat (12) @(posedge mclk);
        cmp("contact_a", 34'h1, {33'h0, coil_a});
        fault_clear <= 1'b1;
        repeat (12) @(posedge mclk);
        fault_clear <= 1'b0;
        cmp("contact_b", 34'h1, {33'h0, coil_b});
        wr(8'h10, 32'h1, DSOF_RESP_OKAY);
        repeat (4) @(posedge mclk);
        cmp("contact_a", 34'h1, {33'h0, coil_a});
        trip_mode <= 1'b1;
        repeat (12) @(posedge mclk);
        trip_mode <= 1'b0;
        repeat (8) @(posedge mclk);
        cmp("contact_a", 34'h0, {33'h0, coil_a});
        wr(8'h10, 32'h2, DSOF_RESP_OKAY);
        repeat (4) @(posedge mclk);
        cmp("contact_b", 34'h1, {33'h0, coil_b});
        wr(8'h0c, 32'h00000500, DSOF_RESP_OKAY);
        trip_mode <= 1'b1;
        repeat (12) @(posedge mclk);
        cmp("relay12", 34'h1, {33'h0, coil12});
        cmp("relay11", 34'h0, {33'h0, coil11});
        cmp("contact_a", 34'h0, {33'h0, coil_a});
        wr(8'h18, 32'h1, DSOF_RESP_SLVERR);
        results();
    end
endmodule : drive_status_output_flags_test
`default_nettype wire
